// ### cantrg_top.sv
// Passive CAN classical, FD and XL frame decoder with trigger and error detection.
//
// Functional notes
// [R01] SOF mode fires on the first falling edge opening a frame.
// [R02] EOF mode fires when the end-of-frame field completes.
// [R03] Frame-type mode fires on data, remote, error or overload, with ID format.
// [R04] ID plus data mode fires at last pattern byte when both match.
// [R05] Base formats take 11 identifier bits, extended take 29; XL frames follow their IDE bit.
// [R06] Remote frames parse like data frames with no data field.
// [R07] Error and overload type ignore the identifier format setting.
// [R08] Identifier match by single value or in/out of range bounds.
// [R09] DLC match is exact or a minimum value.
// [R10] 11-bit identifier evaluated at the IDE bit sample point.
// [R11] 29-bit identifier evaluated at the RTR bit sample point.
// [R12] Any format ignores identifier; ID mode fires always, combined checks data.
// [R13] FD frames compare BRS and ESI as 0, 1 or don't care.
// [R14] XL frames compare SDT, VCID and AF by value or range.
// [R15] XL frames compare the SEC bit to a set value.
// [R16] Protocol errors are found independently of any error flag.
// [R17] Illegal level in a fixed-form field gives a form error.
// [R18] Sixth equal bit in the stuffed fields gives a stuff error.
// [R19] Recessive acknowledge slot gives an acknowledge error.
// [R20] Computed CRC differing from received CRC gives a checksum error in classical frames only.
// [R21] Frame not wholly inside the capture window is marked incomplete.
// [R22] Each frame gets an index, a start time and an overall state.
// [R23] Trigger is a one-cycle pulse; reset clears all match state.
`timescale 1ns/1ps
`default_nettype none
`include "cantrg_map.svh"
module cantrg_top
  import cantrg_pkg::*;
#(
  parameter int BIT_CYC = `CT_CLK_HZ / `CT_BITRATE,
  parameter int SP_CYC = BIT_CYC * `CT_SP_PCT / 100
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic can_rx,
  input wire logic acq_active,
  input wire cantrg_mode_e trig_mode,
  input wire cantrg_ftype_e ftype_sel,
  input wire cantrg_idtype_e id_type,
  input wire cantrg_cmp_e id_cond,
  input wire logic [28:0] id_lo,
  input wire logic [28:0] id_hi,
  input wire logic dlc_min_mode,
  input wire logic [10:0] dlc_ref,
  input wire cantrg_cmp_e data_cond,
  input wire logic [63:0] data_lo,
  input wire logic [63:0] data_hi,
  input wire logic [3:0] data_len,
  input wire cantrg_bit_e brs_cfg,
  input wire cantrg_bit_e esi_cfg,
  input wire cantrg_cmp_e sdt_cond,
  input wire logic [7:0] sdt_lo,
  input wire logic [7:0] sdt_hi,
  input wire cantrg_cmp_e vcid_cond,
  input wire logic [7:0] vcid_lo,
  input wire logic [7:0] vcid_hi,
  input wire cantrg_cmp_e af_cond,
  input wire logic [31:0] af_lo,
  input wire logic [31:0] af_hi,
  input wire logic sec_cfg,
  input wire logic [3:0] err_en,
  output logic trig,
  output logic frame_done,
  output logic [15:0] frame_index,
  output logic [31:0] frame_start,
  output cantrg_state_e frame_state,
  output cantrg_ftype_e frame_type,
  output logic [28:0] frame_id,
  output logic [3:0] err_pulse,
  output logic busy
);
  // ************************************************************
  // Helpers
  // ************************************************************
  localparam logic [7:0] BIT_LAST = 8'(BIT_CYC - 1);
  localparam logic [7:0] SP_B = 8'(SP_CYC);

  // One CRC-15 step for one received bit.
  function automatic logic [14:0] crc_step(input logic [14:0] c, input logic b);
    crc_step = {c[13:0], 1'b0} ^ ((b ^ c[14]) ? `CT_CRC15_POLY : 15'h0000);
  endfunction

  // Data bytes coded by the length code for each frame family.
  function automatic logic [11:0] dlc_bytes(input logic [10:0] d, input logic fd,
                                             input logic xl, input logic rtr);
    dlc_bytes = {1'b0, d};
    if (xl) begin
      dlc_bytes = {1'b0, d} + 12'h001;
    end else if (!fd && rtr) begin
      dlc_bytes = 12'h000;
    end else if (!fd) begin
      dlc_bytes = (d > `CT_DLC_MAX_CL) ? 12'h008 : {1'b0, d};
    end else begin
      case (d[3:0])
        4'h9: dlc_bytes = 12'h00c;
        4'ha: dlc_bytes = 12'h010;
        4'hb: dlc_bytes = 12'h014;
        4'hc: dlc_bytes = 12'h018;
        4'hd: dlc_bytes = 12'h020;
        4'he: dlc_bytes = 12'h030;
        4'hf: dlc_bytes = 12'h040;
        default: dlc_bytes = {8'h00, d[3:0]};
      endcase
    end
  endfunction

  // Bit condition of 0, 1 or don't care.
  function automatic logic bit_ok(input cantrg_bit_e c, input logic v);
    bit_ok = (c == CT_BIT_X) || (v == (c == CT_BIT_1));
  endfunction

  cantrg_st_s r;
  cantrg_st_s n;
  logic rxb;
  logic [28:0] id_val;
  logic [31:0] af_val;
  logic [63:0] data_mask;
  logic [63:0] data_val;
  logic id_m;
  logic data_m;
  logic sdt_m;
  logic vcid_m;
  logic af_m;

  // ************************************************************
  // Field comparators
  // ************************************************************
  assign rxb = r.sync2;
  assign id_val = (r.fld == F_IDE) ? {18'h0_0000, r.id_a} : {r.id_a, r.id_b};
  assign af_val = {r.sh[30:0], rxb};
  assign data_mask = (data_len >= 4'h8) ? 64'hffff_ffff_ffff_ffff :
                     ~(64'hffff_ffff_ffff_ffff << {data_len[2:0], 3'b000});
  assign data_val = {r.sh[62:0], rxb} & data_mask;

  cantrg_cmp #(.W(29)) u_id (.mode(id_cond), .lo(id_lo), .hi(id_hi), .val(id_val),
    .match(id_m)); // [R08]
  cantrg_cmp #(.W(64)) u_data (.mode(data_cond), .lo(data_lo & data_mask),
    .hi(data_hi & data_mask), .val(data_val), .match(data_m));
  cantrg_cmp #(.W(8)) u_sdt (.mode(sdt_cond), .lo(sdt_lo), .hi(sdt_hi), .val(r.sdt),
    .match(sdt_m)); // [R14]
  cantrg_cmp #(.W(8)) u_vcid (.mode(vcid_cond), .lo(vcid_lo), .hi(vcid_hi),
    .val(r.vcid), .match(vcid_m)); // [R14]
  cantrg_cmp #(.W(32)) u_af (.mode(af_cond), .lo(af_lo), .hi(af_hi), .val(af_val),
    .match(af_m)); // [R14]

  // ************************************************************
  // Next state
  // ************************************************************
  // Bit timing, destuffing, field walk, matching and error checks.
  always_comb begin
    logic [63:0] nsh;
    logic [11:0] nb;
    logic last;
    logic fire;
    logic fmt_ok;
    logic dlc_ok;
    logic e_form;
    logic e_stuff;
    logic e_ack;
    logic e_crc;
    cantrg_ftype_e ft;
    nsh = {r.sh[62:0], rxb};
    nb = dlc_bytes(r.dlc, r.fdf, r.xl, r.rtr);
    last = (r.fcnt == 15'h0000);
    fire = 1'b0;
    e_form = 1'b0;
    e_stuff = 1'b0;
    e_ack = 1'b0;
    e_crc = 1'b0;
    fmt_ok = (id_type == CT_ID_ANY) || ((id_type == CT_ID_29) == r.ide);
    dlc_ok = dlc_min_mode ? (r.dlc >= dlc_ref) : (r.dlc == dlc_ref); // [R09]
    ft = r.fdf ? (r.ide ? CT_FT_FEFF : CT_FT_FBFF) :
         (r.ide ? (r.rtr ? CT_FT_CEFF_R : CT_FT_CEFF) : (r.rtr ? CT_FT_CBFF_R : CT_FT_CBFF));
    n = r;
    n.trig = 1'b0;
    n.frame_done = 1'b0;
    n.err_pulse = 4'h0;
    n.sync1 = can_rx;
    n.sync2 = r.sync1;
    n.prev = r.sync2;
    n.tstamp = r.tstamp + 32'h0000_0001;
    if (!acq_active && r.busy) begin
      n.incomp = 1'b1; // [R21]
    end
    // Any recessive-to-dominant edge restarts the bit time.
    if (r.prev && !rxb) begin
      n.bcnt = 8'h01;
    end else if (r.bcnt == BIT_LAST) begin
      n.bcnt = 8'h00;
    end else begin
      n.bcnt = r.bcnt + 8'h01;
    end
    if (r.fld == F_IDLE && r.prev && !rxb) begin
      n.fld = F_SOF;
      n.fcnt = 15'h0000;
      n.busy = 1'b1;
      n.stuff_on = 1'b1;
      n.run_cnt = 3'h0;
      n.run_lvl = 1'b0;
      n.crc = 15'h0000;
      n.dbytes = 4'h0;
      n.id_ok = 1'b0;
      n.errd = 1'b0;
      n.xl = 1'b0;
      n.frame_type = CT_FT_NONE;
      n.frame_index = r.frame_index + 16'h0001; // [R22]
      n.frame_start = r.tstamp; // [R22]
      n.incomp = !acq_active; // [R21]
      fire = (trig_mode == CT_TM_SOF); // [R01]
    end else if (r.bcnt == SP_B && r.fld != F_IDLE) begin
      if (r.stuff_on && r.run_cnt == `CT_STUFF_RUN && rxb == r.run_lvl) begin
        e_stuff = 1'b1; // [R18]
        n.errd = !rxb;
      end else if (r.stuff_on && r.run_cnt == `CT_STUFF_RUN) begin
        n.run_lvl = rxb; // [R18]
        n.run_cnt = 3'h1;
      end else begin
        if (r.stuff_on) begin
          n.run_cnt = (rxb == r.run_lvl) ? r.run_cnt + 3'h1 : 3'h1;
          n.run_lvl = rxb;
        end
        if (r.stuff_on && r.fld != F_CRC) begin
          n.crc = crc_step(r.crc, rxb); // [R20]
        end
        n.sh = nsh;
        n.fcnt = r.fcnt - 15'h0001;
        case (r.fld)
          F_SOF: begin
            n.fld = rxb ? F_IDLE : F_ID_A;
            n.busy = !rxb;
            n.fcnt = `CT_LEN_ID_A - 15'h0001;
          end
          F_ID_A: begin
            if (last) begin
              n.id_a = nsh[10:0]; // [R05]
              n.fld = F_RTR1;
            end
          end
          F_RTR1: begin
            n.rtr = rxb;
            n.fld = F_IDE;
          end
          F_IDE: begin
            n.ide = rxb;
            if (rxb) begin
              n.fld = F_ID_B;
              n.fcnt = `CT_LEN_ID_B - 15'h0001;
            end else begin
              n.fld = F_FDF;
              n.frame_id = {18'h0_0000, r.id_a};
              n.id_ok = (id_type == CT_ID_ANY) || (id_type == CT_ID_11 && id_m); // [R12]
              fire = (trig_mode == CT_TM_ID) && n.id_ok; // [R10]
            end
          end
          F_ID_B: begin
            if (last) begin
              n.id_b = nsh[17:0]; // [R05]
              n.fld = F_RTR2;
            end
          end
          F_RTR2: begin
            n.rtr = rxb;
            n.fld = F_FDF;
            n.frame_id = {r.id_a, r.id_b};
            n.id_ok = (id_type == CT_ID_ANY) || (id_type == CT_ID_29 && id_m); // [R12]
            fire = (trig_mode == CT_TM_ID) && n.id_ok; // [R11]
          end
          F_FDF: begin
            n.fdf = rxb;
            n.fld = rxb ? F_XLF : (r.ide ? F_R0 : F_DLC);
            n.fcnt = `CT_LEN_DLC - 15'h0001;
          end
          F_R0: begin
            n.fld = F_DLC;
            n.fcnt = `CT_LEN_DLC - 15'h0001;
          end
          F_XLF: begin
            n.xl = rxb;
            n.fld = rxb ? F_SDT : F_BRS;
            n.fcnt = `CT_LEN_SDT - 15'h0001;
          end
          F_BRS: begin
            n.brs = rxb;
            n.fld = F_ESI;
          end
          F_ESI: begin
            n.esi = rxb;
            n.fld = F_DLC;
            n.fcnt = `CT_LEN_DLC - 15'h0001;
          end
          F_SDT: begin
            if (last) begin
              n.sdt = nsh[7:0];
              n.fld = F_SEC;
            end
          end
          F_SEC: begin
            n.sec = rxb;
            n.fld = F_DLC;
            n.fcnt = `CT_LEN_DLC_XL - 15'h0001;
          end
          F_DLC: begin
            if (last) begin
              n.dlc = r.xl ? nsh[10:0] : {7'h00, nsh[3:0]};
              nb = dlc_bytes(n.dlc, r.fdf, r.xl, r.rtr); // [R06]
              if (r.xl) begin
                n.fld = F_VCID;
                n.fcnt = `CT_LEN_VCID - 15'h0001;
              end else begin
                n.frame_type = ft;
                fire = (trig_mode == CT_TM_FTYPE) && (ftype_sel == ft) && fmt_ok &&
                       (!r.fdf || (bit_ok(brs_cfg, r.brs) && bit_ok(esi_cfg, r.esi))); // [R03] [R13]
                n.fld = (nb == 12'h000) ? F_CRC : F_DATA;
                n.fcnt = (nb == 12'h000) ? (r.fdf ? `CT_LEN_CRC_FD_S : `CT_LEN_CRC15) - 15'h0001
                         : {nb, 3'b000} - 15'h0001;
              end
            end
          end
          F_VCID: begin
            if (last) begin
              n.vcid = nsh[7:0];
              n.fld = F_AF;
              n.fcnt = `CT_LEN_AF - 15'h0001;
            end
          end
          F_AF: begin
            if (last) begin
              n.frame_type = CT_FT_XLFF;
              fire = (trig_mode == CT_TM_FTYPE) && (ftype_sel == CT_FT_XLFF) && fmt_ok &&
                     sdt_m && vcid_m && af_m && (r.sec == sec_cfg); // [R14] [R15]
              n.fld = F_DATA;
              n.fcnt = {nb, 3'b000} - 15'h0001;
            end
          end
          F_DATA: begin
            if (r.fcnt[2:0] == 3'h0) begin
              n.dbytes = (r.dbytes == 4'hf) ? r.dbytes : r.dbytes + 4'h1;
              fire = (trig_mode == CT_TM_ID_DATA) && (r.dbytes + 4'h1 == data_len) &&
                     r.id_ok && dlc_ok && data_m; // [R04]
            end
            if (last) begin
              n.fld = F_CRC;
              n.fcnt = r.xl ? `CT_LEN_CRC_XL - 15'h0001 :
                       !r.fdf ? `CT_LEN_CRC15 - 15'h0001 :
                       (nb > 12'h010) ? `CT_LEN_CRC_FD_L - 15'h0001 :
                       `CT_LEN_CRC_FD_S - 15'h0001;
            end
          end
          F_CRC: begin
            if (last) begin
              e_crc = !r.fdf && (r.crc != nsh[14:0]); // [R20]
              n.fld = F_CRCDEL;
            end
          end
          F_CRCDEL: begin
            n.stuff_on = 1'b0;
            e_form = !rxb; // [R17]
            n.fld = F_ACK;
          end
          F_ACK: begin
            e_ack = rxb; // [R19]
            n.fld = F_ACKDEL;
          end
          F_ACKDEL: begin
            e_form = !rxb; // [R17]
            n.fld = F_EOF;
            n.fcnt = `CT_LEN_EOF - 15'h0001;
          end
          F_EOF: begin
            e_form = !rxb; // [R17]
            if (rxb && last) begin
              n.frame_done = 1'b1;
              n.frame_state = r.incomp ? CT_ST_INCOMPLETE : CT_ST_OK; // [R22]
              fire = (trig_mode == CT_TM_EOF); // [R02]
              n.fld = F_IFS;
              n.fcnt = `CT_LEN_IFS - 15'h0001;
            end
          end
          F_IFS: begin
            if (!rxb) begin
              n.frame_type = CT_FT_OVERLOAD;
              fire = (trig_mode == CT_TM_FTYPE) && (ftype_sel == CT_FT_OVERLOAD); // [R07]
              n.fld = F_RECOV;
              n.fcnt = `CT_LEN_RECOV - 15'h0001;
            end else if (last) begin
              n.fld = F_IDLE;
              n.busy = 1'b0;
            end
          end
          F_RECOV: begin
            if (!rxb) begin
              n.fcnt = `CT_LEN_RECOV - 15'h0001;
            end else if (last) begin
              n.fld = F_IDLE;
              n.busy = 1'b0;
            end
          end
          default: begin
            n.fld = F_IDLE;
          end
        endcase
      end
    end
    // Any error ends the frame and waits for the bus to recover.
    if (e_form || e_stuff || e_ack || e_crc) begin
      n.err_pulse = {e_crc, e_ack, e_stuff, e_form}; // [R16]
      n.fld = F_RECOV;
      n.fcnt = `CT_LEN_RECOV - 15'h0001;
      n.stuff_on = 1'b0;
      n.frame_done = 1'b1;
      n.frame_state = r.incomp ? CT_ST_INCOMPLETE : CT_ST_ERROR; // [R21]
      if (e_stuff && !rxb) begin
        n.frame_type = CT_FT_ERROR;
      end
      fire = ((trig_mode == CT_TM_ERROR) && ((err_en & n.err_pulse) != 4'h0)) ||
             ((trig_mode == CT_TM_FTYPE) && (ftype_sel == CT_FT_ERROR) &&
              e_stuff && !rxb); // [R16] [R07]
    end
    n.trig = fire; // [R23]
  end

  // ************************************************************
  // State register
  // ************************************************************
  // All state and outputs clear on reset; the line idles recessive.
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      r <= '0; // [R23]
      r.sync1 <= 1'b1;
      r.sync2 <= 1'b1;
      r.prev <= 1'b1;
      r.frame_type <= CT_FT_NONE;
    end else begin
      r <= n;
    end
  end

  assign trig = r.trig;
  assign frame_done = r.frame_done;
  assign frame_index = r.frame_index;
  assign frame_start = r.frame_start;
  assign frame_state = r.frame_state;
  assign frame_type = r.frame_type;
  assign frame_id = r.frame_id;
  assign err_pulse = r.err_pulse;
  assign busy = r.busy;
endmodule
`default_nettype wire

// ### cantrg_map.svh
// Lengths of fields, bit timing and fixed constants for the CAN trigger.
`ifndef CANTRG_MAP_SVH
`define CANTRG_MAP_SVH
// ************************************************************
// Bit timing
// ************************************************************
`define CT_CLK_HZ 32'h0262_5a00
`define CT_BITRATE 32'h0007_a120
`define CT_SP_PCT 32'h0000_0046
// ************************************************************
// Field lengths in bits
// ************************************************************
`define CT_LEN_ID_A 15'h000b
`define CT_LEN_ID_B 15'h0012
`define CT_LEN_DLC 15'h0004
`define CT_LEN_DLC_XL 15'h000b
`define CT_LEN_SDT 15'h0008
`define CT_LEN_VCID 15'h0008
`define CT_LEN_AF 15'h0020
`define CT_LEN_CRC15 15'h000f
`define CT_LEN_CRC_FD_S 15'h0015
`define CT_LEN_CRC_FD_L 15'h0019
`define CT_LEN_CRC_XL 15'h0020
`define CT_LEN_EOF 15'h0007
`define CT_LEN_IFS 15'h0003
`define CT_LEN_RECOV 15'h000b
// ************************************************************
// Coding constants
// ************************************************************
`define CT_CRC15_POLY 15'h4599
`define CT_STUFF_RUN 3'h5
`define CT_DLC_MAX_CL 11'h008
`endif

// ### cantrg_pkg.sv
// Types shared by the CAN trigger modules.
package cantrg_pkg;
  typedef enum logic [2:0] {
    CT_TM_SOF, CT_TM_EOF, CT_TM_FTYPE, CT_TM_ID, CT_TM_ID_DATA, CT_TM_ERROR
  } cantrg_mode_e;
  typedef enum logic [3:0] {
    CT_FT_CBFF, CT_FT_CBFF_R, CT_FT_CEFF, CT_FT_CEFF_R, CT_FT_FBFF, CT_FT_FEFF,
    CT_FT_XLFF, CT_FT_ERROR, CT_FT_OVERLOAD, CT_FT_NONE
  } cantrg_ftype_e;
  typedef enum logic [1:0] {CT_ID_11, CT_ID_29, CT_ID_ANY} cantrg_idtype_e;
  typedef enum logic [1:0] {CT_CMP_EQ, CT_CMP_NE, CT_CMP_IN, CT_CMP_OUT} cantrg_cmp_e;
  typedef enum logic [1:0] {CT_BIT_0, CT_BIT_1, CT_BIT_X} cantrg_bit_e;
  typedef enum logic [1:0] {CT_ST_OK, CT_ST_ERROR, CT_ST_INCOMPLETE} cantrg_state_e;
  typedef enum logic [4:0] {
    F_IDLE, F_SOF, F_ID_A, F_RTR1, F_IDE, F_ID_B, F_RTR2, F_FDF, F_R0, F_XLF,
    F_BRS, F_ESI, F_DLC, F_SDT, F_SEC, F_VCID, F_AF, F_DATA, F_CRC, F_CRCDEL,
    F_ACK, F_ACKDEL, F_EOF, F_IFS, F_RECOV
  } cantrg_fld_e;
  typedef struct packed {
    logic sync1;
    logic sync2;
    logic prev;
    logic [7:0] bcnt;
    cantrg_fld_e fld;
    logic [14:0] fcnt;
    logic [63:0] sh;
    logic stuff_on;
    logic [2:0] run_cnt;
    logic run_lvl;
    logic [14:0] crc;
    logic [10:0] id_a;
    logic [17:0] id_b;
    logic rtr;
    logic ide;
    logic fdf;
    logic xl;
    logic brs;
    logic esi;
    logic sec;
    logic [10:0] dlc;
    logic [7:0] sdt;
    logic [7:0] vcid;
    logic [3:0] dbytes;
    logic id_ok;
    logic incomp;
    logic errd;
    logic [31:0] tstamp;
    logic trig;
    logic frame_done;
    logic [15:0] frame_index;
    logic [31:0] frame_start;
    cantrg_state_e frame_state;
    cantrg_ftype_e frame_type;
    logic [28:0] frame_id;
    logic [3:0] err_pulse;
    logic busy;
  } cantrg_st_s;
endpackage

// ### cantrg_cmp.sv
// Value or range comparator used for the identifier, data, SDT, VCID and AF matches of the CAN trigger.
`timescale 1ns/1ps
`default_nettype none
module cantrg_cmp
  import cantrg_pkg::*;
#(
  parameter int W = 8
) (
  input wire cantrg_cmp_e mode,
  input wire logic [W-1:0] lo,
  input wire logic [W-1:0] hi,
  input wire logic [W-1:0] val,
  output logic match
);
  // ************************************************************
  // Comparison
  // ************************************************************
  logic in_rng;
  assign in_rng = (val >= lo) && (val <= hi);
  // Single value, its negation, inside or outside the bounds.
  always_comb begin
    case (mode)
      CT_CMP_EQ: match = (val == lo);
      CT_CMP_NE: match = (val != lo);
      CT_CMP_IN: match = in_rng;
      CT_CMP_OUT: match = !in_rng;
      default: match = 1'b0;
    endcase
  end
endmodule
`default_nettype wire

// ### cantrg_top_assertions.sv
// Concurrent checks on the ports of the CAN trigger top module.
`timescale 1ns/1ps
`default_nettype none
module cantrg_top_assertions
  import cantrg_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire cantrg_mode_e trig_mode,
  input wire logic trig,
  input wire logic frame_done,
  input wire logic [15:0] frame_index,
  input wire cantrg_state_e frame_state,
  input wire cantrg_ftype_e frame_type,
  input wire logic [3:0] err_pulse,
  input wire logic busy
);
  // All checks run on the system clock and pause while reset is held.
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  a_trig_pulse: assert property (trig |=> !trig)
    else $error("trig held longer than one cycle");
  a_done_pulse: assert property (frame_done |=> !frame_done)
    else $error("frame_done held longer than one cycle");
  a_err_pulse: assert property (|err_pulse |=> err_pulse == 4'h0)
    else $error("err_pulse held longer than one cycle");
  a_sof_fire: assert property (trig_mode == CT_TM_SOF && $rose(busy) |-> ##[0:2] trig)
    else $error("no trigger at frame start");
  a_eof_fire: assert property (trig_mode == CT_TM_EOF && trig |->
    frame_done && frame_state != CT_ST_ERROR)
    else $error("end trigger without a clean frame end");
  a_err_ends: assert property (|err_pulse |-> ##[0:2] (frame_done && frame_state != CT_ST_OK))
    else $error("error did not close the frame");
  a_idx_step: assert property ($changed(frame_index) |->
    frame_index == $past(frame_index) + 16'h0001)
    else $error("frame index did not step by one");
  a_rst_clear: assert property ($rose(rst_b) |-> !trig && !busy && frame_type == CT_FT_NONE)
    else $error("state not clear after reset");
endmodule
`default_nettype wire

// ### cantrg_bus_node.sv
// Bus node model that sends one frame on the CAN line with bit stuffing.
`timescale 1ns/1ps
`default_nettype none
module cantrg_bus_node #(
  parameter int BIT_CYC = 16
) (
  input wire logic clk_sys,
  output logic can_rx
);
  // The line rests recessive, which is also its released level.
  initial can_rx = 1'h1;
  // Drives one bit for a whole bit time, changing just after an edge.
  task automatic put(input logic v);
    @(posedge clk_sys);
    #1 can_rx = v;
    repeat (BIT_CYC - 1) @(posedge clk_sys);
  endtask
  // Sends n bits MSB first; the first ns get a stuff bit after five equal levels.
  task automatic send(input logic [127:0] b, input int n, input int ns);
    int run;
    logic lvl;
    run = 0;
    lvl = 1'h1;
    for (int i = n - 1; i >= 0; i--) begin
      put(b[i]);
      run = (b[i] == lvl) ? run + 1 : 1;
      lvl = b[i];
      if (n - i <= ns && run == 5) begin
        put(~lvl);
        lvl = ~lvl;
        run = 1;
      end
    end
  endtask
endmodule
`default_nettype wire

// ### can_protocol_trigger_tb.sv
// Self-checking bench for the CAN trigger with a frame-level reference model.
`timescale 1ns/1ps
`default_nettype none
`include "cantrg_map.svh"
module can_protocol_trigger_tb
  import cantrg_pkg::*;
;
  localparam int BC = 16;
  logic clk_sys = 1'h0, rst_b = 1'h0, acq_active = 1'h1, can_rx, trig, frame_done, busy;
  logic bsy_q = 1'h0, dmm = 1'h1;
  logic [31:0] frame_start;
  int tcnt = 0, tsof = 0;
  cantrg_idtype_e it = CT_ID_11;
  cantrg_mode_e trig_mode = CT_TM_SOF;
  cantrg_ftype_e ft = CT_FT_CBFF, frame_type;
  cantrg_cmp_e cc = CT_CMP_EQ;
  cantrg_bit_e bx = CT_BIT_X;
  cantrg_state_e frame_state, st;
  logic [28:0] id_lo = 29'h0000_0000, frame_id;
  logic [63:0] data_lo = 64'h0000_0000_0000_0000;
  logic [7:0] rb = 8'h00;
  logic [3:0] err_en = 4'hf, err_pulse, errs;
  logic [15:0] frame_index;
  int num_errors = 0, num_checks = 0, cyc = 0, ntrig = 0, nf = 0;
  cantrg_top #(.BIT_CYC(BC), .SP_CYC(10)) uut (.clk_sys(clk_sys), .rst_b(rst_b),
    .can_rx(can_rx), .acq_active(acq_active), .trig_mode(trig_mode), .ftype_sel(ft),
    .id_type(it), .id_cond(cc), .id_lo(id_lo), .id_hi(id_lo), .dlc_min_mode(dmm),
    .dlc_ref(11'h001), .data_cond(cc), .data_lo(data_lo), .data_hi(data_lo),
    .data_len(4'h1), .brs_cfg(bx), .esi_cfg(bx), .sdt_cond(cc), .sdt_lo(rb), .sdt_hi(rb),
    .vcid_cond(cc), .vcid_lo(rb), .vcid_hi(rb), .af_cond(cc), .af_lo({4{rb}}),
    .af_hi({4{rb}}), .sec_cfg(1'h0), .err_en(err_en), .trig(trig), .frame_done(frame_done),
    .frame_index(frame_index), .frame_start(frame_start), .frame_state(frame_state),
    .frame_type(frame_type), .frame_id(frame_id), .err_pulse(err_pulse), .busy(busy));
  cantrg_bus_node #(.BIT_CYC(BC)) node (.clk_sys(clk_sys), .can_rx(can_rx));
  // Clock at 40 MHz.
  initial forever #12.5 clk_sys = ~clk_sys;
  // Collects pulses per frame and cuts a hang short.
  always @(posedge clk_sys) begin
    cyc++;
    ntrig += trig;
    errs |= err_pulse;
    if (frame_done) st = frame_state;
    // Cycles since reset; the start stamp is the count before the edge that raised busy.
    if (rst_b) tcnt++;
    if (busy && !bsy_q) tsof = tcnt - 2;
    bsy_q = busy;
    if (cyc == 30000) begin
      num_errors++;
      final_report();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Sends one base data frame of one byte; k picks a fault, x spoils the match.
  task automatic run(input cantrg_mode_e m, input int k, input logic acq, input logic x);
    logic [10:0] id;
    logic [127:0] b;
    logic [14:0] c;
    int e;
    id = 11'($urandom);
    rb = 8'($urandom);
    b = {1'h0, id, 7'h01, rb};
    c = 15'h0000;
    for (int i = 26; i >= 0; i--) c = {c[13:0], 1'h0} ^ ((b[i] ^ c[14]) ? `CT_CRC15_POLY : 15'h0);
    b = {b[102:0], c ^ 15'(k == 2), 1'(k != 3), 1'(k == 1), 8'hff};
    @(posedge clk_sys);
    #1 trig_mode = m;
    id_lo = {18'h0_0000, id ^ 11'(x)};
    data_lo = {56'h0, rb ^ 8'(x)};
    acq_active = acq;
    it = ($urandom % 2) ? CT_ID_ANY : CT_ID_11;
    dmm = 1'($urandom);
    ntrig = 0;
    errs = 4'h0;
    st = cantrg_state_e'(2'h3);
    node.send(b, 52, 42);
    repeat (16 * BC) @(posedge clk_sys);
    nf++;
    case (m)
      CT_TM_EOF: e = (k == 0);
      CT_TM_ERROR: e = (k != 0);
      CT_TM_ID: e = !x || it == CT_ID_ANY;
      CT_TM_ID_DATA: e = !x;
      default: e = 1;
    endcase
    chk(ntrig, e);
    chk(errs, k == 1 ? 4'h4 : k == 2 ? 4'h8 : k == 3 ? 4'h1 : 4'h0);
    chk(st, !acq ? CT_ST_INCOMPLETE : k != 0 ? CT_ST_ERROR : CT_ST_OK);
    chk(frame_id, {18'h0_0000, id});
    chk(frame_index, nf);
    chk(frame_start, tsof);
    chk(busy, 1'h0);
    if (k == 0) chk(frame_type, CT_FT_CBFF);
  endtask
  task automatic final_report();
    $display("checks=%0d errors=%0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Main sequence: every trigger mode, the ack, CRC and form faults and a partial capture.
  initial begin
    void'($urandom(50));
    repeat (16) @(posedge clk_sys);
    #1 rst_b = 1'h1;
    repeat (8) @(posedge clk_sys);
    run(CT_TM_SOF, 0, 1'h1, 1'h0);
    run(CT_TM_EOF, 0, 1'h1, 1'h0);
    run(CT_TM_FTYPE, 0, 1'h1, 1'h0);
    run(CT_TM_ID, 0, 1'h1, 1'h0);
    run(CT_TM_ID, 0, 1'h1, 1'h1);
    run(CT_TM_ID_DATA, 0, 1'h1, 1'h0);
    run(CT_TM_ID_DATA, 0, 1'h1, 1'h1);
    for (int k = 1; k <= 3; k++) run(CT_TM_ERROR, k, 1'h1, 1'h0);
    run(CT_TM_EOF, 1, 1'h1, 1'h0);
    run(CT_TM_SOF, 0, 1'h0, 1'h0);
    final_report();
  end
endmodule
bind cantrg_top cantrg_top_assertions u_chk (.clk_sys(clk_sys), .rst_b(rst_b),
  .trig_mode(trig_mode), .trig(trig), .frame_done(frame_done), .frame_index(frame_index),
  .frame_state(frame_state), .frame_type(frame_type), .err_pulse(err_pulse), .busy(busy));
`default_nettype wire
